// *** logic/tafl_pkg.sv ***
// Constants, field positions and reset values of the temperature alarm and fault logic.
// Assumes one 40 MHz clock and conversion results delivered by an analog front end.
// Functional notes
// - Low byte holds fraction in upper nibble, sixteenth steps; lower nibble always zero.
// - Low-byte fraction format is identical in standard and extended range.
// - Extended range high byte is unsigned, one degree per count, zero means -64.
// - Standard range high byte is one degree per count, two's complement.
// - Beta current range is chosen automatically at the start of every conversion.
// - Diode fault during conversion keeps last remote result, still updates local, and sets status bit 2.
// - Alarm outputs only pull low, otherwise released, for wired-OR use.
// - Critical output asserts when local or remote exceeds its critical limit.
// - No software control masks or disables the critical output.
// - Critical output releases only once temperature falls below limit minus hysteresis; code already releases at limit minus hysteresis.
// - Critical hysteresis resets to ten degrees.
// - Configuration bit 5 selects warning (0, default) or second critical (1).
// - Second critical behaves like critical, using high limits, ignoring warning suppress.
// - Warning asserts when local or remote violates its high or low limit.
// - Warning asserts only after one to four consecutive violating conversions.
// - Warning also asserts on open remote diode when warning enabled.
// - Configuration bit 7 set keeps the warning output deasserted.
// - Warning releases on address read only if cause gone and status cleared.
// - Standard range clamps below zero to 00h and above 127 to 7Fh.
// - Range bit 2 change takes effect from the next conversion.
package tafl_pkg;
  // ----------------------------------------------------------------
  // Configuration and status fields
  // ----------------------------------------------------------------
  localparam int CFG_RANGE_BIT = 2;
  localparam int CFG_PINSEL_BIT = 5;
  localparam int CFG_SUPPRESS_BIT = 7;
  localparam int STAT_OPEN_BIT = 2;
  localparam int STAT_RLOW_BIT = 3;
  localparam int STAT_RHIGH_BIT = 4;
  localparam int STAT_LLOW_BIT = 5;
  localparam int STAT_LHIGH_BIT = 6;
  // ----------------------------------------------------------------
  // Data format
  // ----------------------------------------------------------------
  localparam logic signed [9:0] EXT_OFFSET = 10'sh040;
  localparam logic signed [9:0] STD_MAX = 10'sh07f;
  localparam logic signed [9:0] EXT_MAX = 10'sh0bf;
  localparam logic signed [9:0] EXT_MIN = -10'sh040;
  localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;
  localparam logic [7:0] HYST_RESET = 8'h0a;
  localparam logic [1:0] CONSEC_RESET = 2'h0;
  // ----------------------------------------------------------------
  // Beta ranging
  // ----------------------------------------------------------------
  localparam int BETA_RANGE_W = 3;
  localparam int BETA_SETTLE_NS = 100;
  localparam int CLK_PERIOD_NS = 25;
  localparam int BETA_SETTLE_CYC = (BETA_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [BETA_RANGE_W-1:0] BETA_RANGE_MAX = 3'h7;
  typedef enum logic [1:0] {TAFL_IDLE, TAFL_RANGING, TAFL_CONVERT} tafl_state_t;
endpackage

// *** logic/tafl_hyst_alarm.sv ***
// Over-limit comparator with release hysteresis for one alarm on both channels.
// Assumes temperatures are signed whole degrees sampled on the conversion update strobe.
`timescale 1ns/10ps
module tafl_hyst_alarm (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Update strobe and inputs
  input wire logic update,
  input wire logic signed [9:0] local_temp,
  input wire logic signed [9:0] remote_temp,
  input wire logic signed [9:0] local_limit,
  input wire logic signed [9:0] remote_limit,
  input wire logic [7:0] hyst,
  // Alarm level, high while active
  output logic active
);
  typedef struct packed {
    logic active;
  } tafl_ha_state_t;
  tafl_ha_state_t st_r, st_nxt;
  logic signed [9:0] hyst_s;
  logic over, under_rel;
  always_comb begin
    st_nxt = st_r;
    hyst_s = $signed({2'b00, hyst});
    over = (local_temp > local_limit) || (remote_temp > remote_limit);
    // Release needs both channels back at or below their limit minus hysteresis
    under_rel = (local_temp <= (local_limit - hyst_s)) && (remote_temp <= (remote_limit - hyst_s));
    if (update) begin
      if (over) begin
        st_nxt.active = 1'b1;
      end else if (under_rel) begin
        st_nxt.active = 1'b0;
      end
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign active = st_r.active;
endmodule // tafl_hyst_alarm

// *** logic/tafl_top.sv ***
// Alarm, data formatting, beta ranging and diode fault logic of a two-channel sensor.
// Assumes the front end gives signed results in sixteenths of a degree with a done strobe.
`timescale 1ns/10ps
module tafl_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Conversion control from the timing engine
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic signed [13:0] local_raw,
  input wire logic signed [13:0] remote_raw,
  // Analog front end status
  input wire logic diode_fault_cmp,
  input wire logic beta_too_low,
  // Configuration
  input wire logic [7:0] config_byte,
  input wire logic [7:0] crit_hyst,
  input wire logic hyst_wr,
  input wire logic [1:0] consec_count,
  input wire logic [7:0] local_high_limit,
  input wire logic [7:0] local_low_limit,
  input wire logic [7:0] remote_high_limit,
  input wire logic [7:0] remote_low_limit,
  input wire logic [7:0] local_crit_limit,
  input wire logic [7:0] remote_crit_limit,
  // Host events
  input wire logic status_read,
  input wire logic address_read,
  // Results
  output logic [7:0] local_high_byte,
  output logic [7:0] local_low_byte,
  output logic [7:0] remote_high_byte,
  output logic [7:0] remote_low_byte,
  output logic [7:0] status_byte,
  output logic [2:0] beta_range,
  output logic range_ext_active,
  // Open-drain alarm pins
  output logic critical_temp_out_o,
  output logic critical_temp_out_oe,
  output logic shared_warning_pin_o,
  output logic shared_warning_pin_oe
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tafl_pkg::tafl_state_t fsm;
    logic [3:0] settle;
    logic [2:0] beta;
    logic ext;
    logic fault_seen;
    logic [7:0] hyst;
    logic signed [13:0] loc;
    logic signed [13:0] rem;
    logic [7:0] status;
    logic [2:0] viol_cnt;
    logic warn;
    logic upd;
    logic crit_oe;
    logic sh_oe;
    logic [7:0] lhb, llb, rhb, rlb;
  } tafl_top_state_t;
  tafl_top_state_t st_r, st_nxt;

  logic crit_act, hi_act;
  logic signed [9:0] loc_deg, rem_deg;
  logic signed [9:0] lhl, lll, rhl, rll, lcl, rcl;
  logic lh_v, ll_v, rh_v, rl_v, any_viol, warn_cause;
  logic [7:0] ev;

  // Limits are read in the active range format
  function automatic logic signed [9:0] lim_deg(input logic [7:0] v, input logic ext);
    if (ext) begin
      lim_deg = $signed({2'b00, v}) - tafl_pkg::EXT_OFFSET;
    end else begin
      lim_deg = {{2{v[7]}}, v};
    end
  endfunction

  // Format one result into high and low bytes
  function automatic logic [15:0] fmt(input logic signed [13:0] raw, input logic ext);
    logic signed [9:0] deg;
    logic signed [9:0] v;
    deg = raw[13:4];
    v = deg;
    if (ext) begin
      if (v < tafl_pkg::EXT_MIN) v = tafl_pkg::EXT_MIN;
      // Extended code tops out at ff, which is the highest whole degree the offset format can carry
      if (v > tafl_pkg::EXT_MAX) v = tafl_pkg::EXT_MAX;
      v = v + tafl_pkg::EXT_OFFSET;
    end else begin
      if (v < 10'sh000) v = 10'sh000;
      if (v > tafl_pkg::STD_MAX) v = tafl_pkg::STD_MAX;
    end
    // Same fraction layout in either range
    fmt = {v[7:0], raw[3:0], tafl_pkg::LOW_NIBBLE_ZERO};
  endfunction

  always_comb begin
    loc_deg = st_r.loc[13:4];
    rem_deg = st_r.rem[13:4];
    lhl = lim_deg(local_high_limit, st_r.ext);
    lll = lim_deg(local_low_limit, st_r.ext);
    rhl = lim_deg(remote_high_limit, st_r.ext);
    rll = lim_deg(remote_low_limit, st_r.ext);
    lcl = lim_deg(local_crit_limit, st_r.ext);
    rcl = lim_deg(remote_crit_limit, st_r.ext);
    lh_v = loc_deg > lhl;
    ll_v = loc_deg < lll;
    rh_v = rem_deg > rhl;
    rl_v = rem_deg < rll;
    any_viol = lh_v || ll_v || rh_v || rl_v;
  end

  // ----------------------------------------------------------------
  // Hysteresis alarms
  // ----------------------------------------------------------------
  tafl_hyst_alarm u_crit (
    .clk(clk),
    .sys_rst(sys_rst),
    .update(st_r.upd),
    .local_temp(loc_deg),
    .remote_temp(rem_deg),
    .local_limit(lcl),
    .remote_limit(rcl),
    .hyst(st_r.hyst),
    .active(crit_act)
  );
  tafl_hyst_alarm u_hi (
    .clk(clk),
    .sys_rst(sys_rst),
    .update(st_r.upd),
    .local_temp(loc_deg),
    .remote_temp(rem_deg),
    .local_limit(lhl),
    .remote_limit(rhl),
    .hyst(st_r.hyst),
    .active(hi_act)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.upd = 1'b0;
    ev = '0;
    if (hyst_wr) begin
      st_nxt.hyst = crit_hyst;
    end
    unique case (st_r.fsm)
      tafl_pkg::TAFL_IDLE: begin
        if (conv_start) begin
          // Range and beta step are chosen afresh for each conversion
          st_nxt.ext = config_byte[tafl_pkg::CFG_RANGE_BIT];
          st_nxt.beta = '0;
          st_nxt.settle = '0;
          st_nxt.fault_seen = 1'b0;
          st_nxt.fsm = tafl_pkg::TAFL_RANGING;
        end
      end
      tafl_pkg::TAFL_RANGING: begin
        if (diode_fault_cmp) st_nxt.fault_seen = 1'b1;
        if (st_r.settle < 4'(tafl_pkg::BETA_SETTLE_CYC - 1)) begin
          st_nxt.settle = st_r.settle + 4'h1;
        end else if (beta_too_low && st_r.beta != tafl_pkg::BETA_RANGE_MAX) begin
          // Step the collector current range until the front end is satisfied or range 7 is reached
          st_nxt.beta = st_r.beta + 3'h1;
          st_nxt.settle = '0;
        end else begin
          st_nxt.fsm = tafl_pkg::TAFL_CONVERT;
        end
      end
      tafl_pkg::TAFL_CONVERT: begin
        if (diode_fault_cmp) st_nxt.fault_seen = 1'b1;
        if (conv_done) begin
          if (!(st_r.fault_seen || diode_fault_cmp)) begin
            st_nxt.loc = local_raw;
            st_nxt.rem = remote_raw;
          end else begin
            // Keep the last good result; only the local channel is independent of the diode
            st_nxt.loc = local_raw;
            ev[tafl_pkg::STAT_OPEN_BIT] = 1'b1;
          end
          st_nxt.upd = 1'b1;
          st_nxt.fsm = tafl_pkg::TAFL_IDLE;
        end
      end
    endcase

    // Limit flags and filter act on the values stored last conversion
    if (st_r.upd) begin
      ev[tafl_pkg::STAT_LHIGH_BIT] = lh_v;
      ev[tafl_pkg::STAT_LLOW_BIT] = ll_v;
      ev[tafl_pkg::STAT_RHIGH_BIT] = rh_v;
      ev[tafl_pkg::STAT_RLOW_BIT] = rl_v;
      if (any_viol) begin
        if (st_r.viol_cnt <= {1'b0, consec_count}) st_nxt.viol_cnt = st_r.viol_cnt + 3'h1;
      end else begin
        st_nxt.viol_cnt = '0;
      end
      {st_nxt.lhb, st_nxt.llb} = fmt(st_r.loc, st_r.ext);
      {st_nxt.rhb, st_nxt.rlb} = fmt(st_r.rem, st_r.ext);
    end

    // A new event wins over a status read in the same cycle
    if (status_read) begin
      st_nxt.status = ev;
    end else begin
      st_nxt.status = st_r.status | ev;
    end

    warn_cause = (st_r.viol_cnt > {1'b0, consec_count}) || st_r.status[tafl_pkg::STAT_OPEN_BIT];
    if (config_byte[tafl_pkg::CFG_SUPPRESS_BIT]) begin
      st_nxt.warn = 1'b0;
    end else if (warn_cause) begin
      st_nxt.warn = 1'b1;
    end else if (address_read && st_r.status == 8'h00) begin
      st_nxt.warn = 1'b0;
    end

    // Critical output has no mask input at all
    st_nxt.crit_oe = crit_act;
    if (config_byte[tafl_pkg::CFG_PINSEL_BIT]) begin
      st_nxt.sh_oe = hi_act;
    end else begin
      st_nxt.sh_oe = st_r.warn;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.fsm <= tafl_pkg::TAFL_IDLE;
      st_r.hyst <= tafl_pkg::HYST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign local_high_byte = st_r.lhb;
  assign local_low_byte = st_r.llb;
  assign remote_high_byte = st_r.rhb;
  assign remote_low_byte = st_r.rlb;
  assign status_byte = st_r.status;
  assign beta_range = st_r.beta;
  assign range_ext_active = st_r.ext;
  // Pins only ever drive low
  assign critical_temp_out_o = 1'b0;
  assign critical_temp_out_oe = st_r.crit_oe;
  assign shared_warning_pin_o = 1'b0;
  assign shared_warning_pin_oe = st_r.sh_oe;
endmodule // tafl_top

// *** tb/tafl_asserts.sv ***
// Port checker for the alarm, format and fault logic.
// Assumes it is bound to tafl_top; one clock domain.
`timescale 1ns/10ps
module tafl_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic conv_done,
  input wire logic status_read,
  input wire logic [7:0] config_byte,
  input wire logic [7:0] local_high_byte,
  input wire logic [7:0] local_low_byte,
  input wire logic [7:0] remote_high_byte,
  input wire logic [7:0] remote_low_byte,
  input wire logic [7:0] status_byte,
  input wire logic range_ext_active,
  input wire logic critical_temp_out_o,
  input wire logic critical_temp_out_oe,
  input wire logic shared_warning_pin_o,
  input wire logic shared_warning_pin_oe
);
  logic [5:0] done_hist_r;
  // Result bytes other than the remote low byte, and the critical pin, may only move within a few cycles of a completion
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_hist_r <= 6'h00;
    end else begin
      done_hist_r <= {done_hist_r[4:0], conv_done};
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence supp_held;
    (config_byte[7] && !config_byte[5]) [*4];
  endsequence
  // ------
  // Assertions
  // ------
  crit_od_a: assert property (!critical_temp_out_o) else $error("crit pin driven high");
  warn_od_a: assert property (!shared_warning_pin_o) else $error("warn pin driven high");
  frac_nibble_a: assert property (local_low_byte[3:0] == 4'h0 && remote_low_byte[3:0] == 4'h0)
    else $error("low nibble set");
  std_clamp_a: assert property ($changed({local_high_byte, remote_high_byte}) && !range_ext_active
    |-> !local_high_byte[7] && !remote_high_byte[7]) else $error("standard byte above 7f");
  supp_mask_a: assert property (supp_held |-> !shared_warning_pin_oe) else $error("warning not masked");
  stat_clear_a: assert property (status_read && !conv_done && done_hist_r[2:0] == 3'h0
    |=> status_byte == 8'h00) else $error("status not cleared");
  stat_cause_a: assert property ($changed(status_byte) |-> $past(status_read) || done_hist_r != 6'h00)
    else $error("status moved alone");
  result_hold_a: assert property ($changed({local_high_byte, local_low_byte, remote_high_byte})
    |-> done_hist_r != 6'h00) else $error("result moved alone");
  crit_cause_a: assert property ($changed(critical_temp_out_oe) |-> done_hist_r != 6'h00)
    else $error("critical pin moved alone");
endmodule // tafl_asserts

bind tafl_top tafl_asserts i_chk (.clk, .sys_rst, .conv_done, .status_read, .config_byte, .local_high_byte,
  .local_low_byte, .remote_high_byte, .remote_low_byte, .status_byte, .range_ext_active, .critical_temp_out_o,
  .critical_temp_out_oe, .shared_warning_pin_o, .shared_warning_pin_oe);

// *** tb/tafl_host_model.sv ***
// Host side of the two open-drain alarm lines, each with a pull-up.
// Assumes the bench calls host_read between conversions.
`timescale 1ns/10ps
module tafl_host_model (
  // Device pins
  input wire logic clk,
  input wire logic crit_o,
  input wire logic crit_oe,
  input wire logic warn_o,
  input wire logic warn_oe,
  // Line levels and host reads
  output logic crit_line,
  output logic warn_line,
  output logic address_read,
  output logic status_read
);
  // A released line floats up to the pull-up level
  assign crit_line = crit_oe ? crit_o : 1'b1;
  assign warn_line = warn_oe ? warn_o : 1'b1;
  initial begin
    address_read = 1'b0;
    status_read = 1'b0;
  end
  task automatic host_read(input bit addr);
    @(posedge clk);
    address_read <= addr;
    status_read <= !addr;
    @(posedge clk);
    address_read <= 1'b0;
    status_read <= 1'b0;
  endtask
endmodule // tafl_host_model

// *** tb/testbench.sv ***
// Self-checking bench: conversions, alarm lines and host reads against a model.
// Assumes tafl_top, its checker and the host model are compiled first.
`timescale 1ns/10ps
module testbench;
  logic clk, sys_rst, conv_start, conv_done, diode_fault_cmp, beta_too_low, hyst_wr;
  logic status_read, address_read, crit_line, warn_line, range_ext_active;
  logic critical_temp_out_o, critical_temp_out_oe, shared_warning_pin_o, shared_warning_pin_oe;
  logic signed [13:0] local_raw, remote_raw;
  logic [7:0] config_byte, crit_hyst, local_high_limit, local_low_limit, remote_high_limit, remote_low_limit;
  logic [7:0] local_crit_limit, remote_crit_limit, local_high_byte, local_low_byte, remote_high_byte;
  logic [7:0] remote_low_byte, status_byte;
  logic [2:0] beta_range;
  logic [1:0] consec_count;
  bit m_crit, m_crit2, m_warn, m_cause;
  bit [7:0] m_stat;
  int m_cnt, m_rem, m_hyst, n_errors, n_compared;
  tafl_top i_dut (.clk, .sys_rst, .conv_start, .conv_done, .local_raw, .remote_raw, .diode_fault_cmp, .beta_too_low,
    .config_byte, .crit_hyst, .hyst_wr, .consec_count, .local_high_limit, .local_low_limit, .remote_high_limit,
    .remote_low_limit, .local_crit_limit, .remote_crit_limit, .status_read, .address_read, .local_high_byte,
    .local_low_byte, .remote_high_byte, .remote_low_byte, .status_byte, .beta_range, .range_ext_active,
    .critical_temp_out_o, .critical_temp_out_oe, .shared_warning_pin_o, .shared_warning_pin_oe);
  tafl_host_model i_host (.clk, .crit_o(critical_temp_out_o), .crit_oe(critical_temp_out_oe),
    .warn_o(shared_warning_pin_o), .warn_oe(shared_warning_pin_oe), .crit_line, .warn_line, .address_read, .status_read);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // About 1450 cycles are needed; fourteen times that means a hang
  initial begin
    #500000;
    n_errors++;
    wrap_up();
  end
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic int hi(input int raw);
    int t;
    t = raw >>> 4;
    if (config_byte[2]) return (t < -64 ? -64 : t > 191 ? 191 : t) + 64;
    return t < 0 ? 0 : t > 127 ? 127 : t;
  endfunction
  function automatic int lim(input logic [7:0] v);
    return config_byte[2] ? int'(v) - 64 : int'($signed(v));
  endfunction
  function automatic bit alarm(input bit st, input int lt, input int rt, input int ll, input int rl);
    if (lt > ll || rt > rl) return 1'b1;
    if (lt <= ll - m_hyst && rt <= rl - m_hyst) return 1'b0;
    return st;
  endfunction
  task automatic chk_warn;
    chk({7'h0, warn_line}, {7'h0, !(config_byte[5] ? m_crit2 : m_warn && !config_byte[7])});
  endtask
  task automatic do_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    config_byte <= 8'h00;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    {m_crit, m_crit2, m_warn, m_cause, m_stat} = 12'h000;
    {m_cnt, m_rem} = 64'h0;
    m_hyst = 10;
  endtask
  task automatic conv(input int loc, input int rem, input bit flt, input bit beta);
    int lt;
    int rt;
    bit [3:0] f;
    @(posedge clk);
    conv_start <= 1'b1;
    local_raw <= 14'(loc);
    remote_raw <= 14'(rem);
    diode_fault_cmp <= flt;
    beta_too_low <= beta;
    @(posedge clk);
    conv_start <= 1'b0;
    // A completion while still ranging must be refused, so it carries junk
    conv_done <= 1'b1;
    local_raw <= ~14'(loc);
    @(posedge clk);
    conv_done <= 1'b0;
    local_raw <= 14'(loc);
    repeat (8) @(posedge clk);
    beta_too_low <= 1'b0;
    repeat (40) @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    diode_fault_cmp <= 1'b0;
    if (flt) m_stat[tafl_pkg::STAT_OPEN_BIT] = 1'b1;
    else m_rem = rem;
    lt = loc >>> 4;
    rt = m_rem >>> 4;
    m_crit = alarm(m_crit, lt, rt, lim(local_crit_limit), lim(remote_crit_limit));
    m_crit2 = alarm(m_crit2, lt, rt, lim(local_high_limit), lim(remote_high_limit));
    f = {lt > lim(local_high_limit), lt < lim(local_low_limit), rt > lim(remote_high_limit), rt < lim(remote_low_limit)};
    m_stat |= {1'b0, f, 3'h0};
    m_cnt = (f != 4'h0) ? m_cnt + 1 : 0;
    m_warn |= (m_cnt > consec_count) || flt;
    m_cause = (f != 4'h0) || flt;
    repeat (6) @(posedge clk);
    chk(local_high_byte, 8'(hi(loc)));
    chk(local_low_byte, {loc[3:0], 4'h0});
    chk(remote_high_byte, 8'(hi(m_rem)));
    chk(remote_low_byte, {m_rem[3:0], 4'h0});
    chk(status_byte, m_stat);
    chk({7'h0, crit_line}, {7'h0, !m_crit});
    chk({7'h0, range_ext_active}, {7'h0, config_byte[2]});
    if (beta) chk({7'h0, beta_range != 3'h0}, 8'h01);
    chk_warn();
  endtask
  task automatic host(input bit addr);
    i_host.host_read(addr);
    if (!addr) m_stat = 8'h00;
    else if (!m_cause && m_stat == 8'h00) m_warn = 1'b0;
    repeat (4) @(posedge clk);
    chk(status_byte, m_stat);
    chk_warn();
  endtask
  // ------
  // Scenarios
  // ------
  initial begin
    {sys_rst, conv_start, conv_done, diode_fault_cmp, beta_too_low, hyst_wr} = 6'h20;
    {local_raw, remote_raw} = 28'h0;
    {config_byte, crit_hyst, consec_count} = 18'h0;
    {local_high_limit, local_low_limit, remote_high_limit, remote_low_limit} = 32'h50055005;
    {local_crit_limit, remote_crit_limit} = 16'h6464;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(71));
    do_reset();
    chk({5'h0, beta_range}, 8'h00);
    chk({6'h0, crit_line, warn_line}, 8'h03);
    repeat (5) conv($urandom_range(160, 1279), $urandom_range(160, 1279), 1'b0, 1'($urandom_range(0, 1)));
    consec_count <= 2'h2;
    repeat (3) conv(1440, 400, 1'b0, 1'b0);
    conv(400, 400, 1'b0, 1'b0);
    host(1'b1);
    host(1'b0);
    host(1'b1);
    consec_count <= 2'h0;
    conv(400, 2000, 1'b1, 1'b0);
    conv(400, 400, 1'b0, 1'b0);
    host(1'b0);
    host(1'b1);
    config_byte <= 8'h80;
    conv(-80, 3200, 1'b0, 1'b0);
    crit_hyst <= 8'h05;
    hyst_wr <= 1'b1;
    @(posedge clk);
    hyst_wr <= 1'b0;
    m_hyst = 5;
    conv(400, 1552, 1'b0, 1'b0);
    conv(400, 1520, 1'b0, 1'b0);
    config_byte <= 8'ha0;
    conv(400, 1360, 1'b0, 1'b0);
    conv(400, 1248, 1'b0, 1'b0);
    conv(400, 1200, 1'b0, 1'b0);
    do_reset();
    conv(400, 1616, 1'b0, 1'b0);
    conv(400, 1456, 1'b0, 1'b0);
    conv(400, 1440, 1'b0, 1'b0);
    config_byte <= 8'h04;
    {local_high_limit, local_low_limit, remote_high_limit, remote_low_limit} <= 32'hff00ff00;
    {local_crit_limit, remote_crit_limit} <= 16'hffff;
    repeat (3) @(posedge clk);
    chk({7'h0, range_ext_active}, 8'h00);
    repeat (4) conv(int'($urandom_range(0, 4095)) - 1024, int'($urandom_range(0, 4095)) - 1024, 1'b0, 1'b0);
    wrap_up();
  end
endmodule // testbench
